// ### can_dyn_pkg.sv
// Shared constants and mode types for the dynamic CAN transaction engine.
package can_dyn_pkg;
  // Memory geometry defaults.
  localparam int DEF_ADDR_W = 9;
  // Parameter block layout: identifier first, then time, then length.
  localparam int ID_BYTES_STD = 2;
  localparam int ID_BYTES_EXT = 4;
  localparam int ID_W = 29;
  localparam int STD_ID_W = 11;
  localparam int OFS_TIME_REL = 0;
  localparam int OFS_LEN_REL = 2;
  localparam int BLK_TAIL_BYTES = 3;
  // Length byte fields.
  localparam int LEN_W = 4;
  localparam int RTR_BIT = 4;
  localparam int MAX_PAYLOAD = 8;
  // Lowest legal nonzero times in ms.
  localparam logic [15:0] TX_TIME_MIN = 16'h0005;
  localparam logic [15:0] RX_TIME_MIN = 16'h000A;
  // Receive status byte.
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_DERR_BIT = 1;
  localparam int STAT_NOTEXEC_BIT = 2;
  localparam logic [2:0] STAT_RESET = 3'h4;
  localparam logic [7:0] MEM_RESET = 8'h00;
  // Millisecond tick derived from the 50 ns clock.
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 50;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  // Offline behaviour and scheduling choices.
  typedef enum logic [1:0] {TX_OFF_CLEAR, TX_OFF_FREEZE, TX_OFF_STOP} tx_offline_t;
  typedef enum logic {RX_OFF_CLEAR, RX_OFF_FREEZE} rx_offline_t;
  typedef enum logic [1:0] {
    UPD_CYCLIC, UPD_CHANGE, UPD_SINGLE, UPD_TRIGGER
  } update_mode_t;
  typedef enum logic {SEQ_IDLE, SEQ_WRITE} seq_state_t;
endpackage

// ### can_dyn_if.sv
// Link between the gateway engine and its master and CAN node peer.
interface can_dyn_if #(parameter int ADDR_W = 9);
  // Process-data memory access by the fieldbus master.
  logic mem_wr;
  logic mem_rd;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic mem_rvalid;
  // Network states.
  logic fb_online;
  logic can_online;
  // Transmit frame towards the CAN node.
  logic tx_valid;
  logic tx_ready;
  logic [28:0] tx_id;
  logic tx_ext;
  logic tx_rtr;
  logic [3:0] tx_len;
  logic [63:0] tx_data;
  // Received frame from the CAN node.
  logic rx_valid;
  logic [28:0] rx_id;
  logic rx_ext;
  logic [3:0] rx_len;
  logic [63:0] rx_data;

  modport gateway (
    input mem_wr, mem_rd, mem_addr, mem_wdata, fb_online, can_online,
    input tx_ready, rx_valid, rx_id, rx_ext, rx_len, rx_data,
    output mem_rdata, mem_rvalid, tx_valid, tx_id, tx_ext, tx_rtr,
    output tx_len, tx_data
  );
  modport peer (
    output mem_wr, mem_rd, mem_addr, mem_wdata, fb_online, can_online,
    output tx_ready, rx_valid, rx_id, rx_ext, rx_len, rx_data,
    input mem_rdata, mem_rvalid, tx_valid, tx_id, tx_ext, tx_rtr,
    input tx_len, tx_data
  );
endinterface

// ### can_dyn_gateway.sv
// Gateway end: shared memory, dynamic transmit and receive transactions.
module can_dyn_gateway
  import can_dyn_pkg::*;
#(
  parameter int ADDR_W = DEF_ADDR_W,
  parameter int MEM_DEPTH = 1 << DEF_ADDR_W,
  parameter int MS_TICKS = MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Link to master and CAN node.
  can_dyn_if.gateway link,
  // Static transmit configuration.
  input wire tx_offline_t tx_offline_mode,
  input wire update_mode_t tx_update_mode,
  input wire logic tx_cnt_en,
  input wire logic [ADDR_W-1:0] tx_cnt_addr,
  input wire logic [ADDR_W-1:0] tx_trig_addr,
  input wire logic [ADDR_W-1:0] tx_dyn_addr,
  input wire logic [ADDR_W-1:0] tx_data_addr,
  input wire logic tx_ext_id,
  input wire logic [3:0] tx_max_len,
  // Static receive configuration.
  input wire rx_offline_t rx_offline_mode,
  input wire logic rx_cnt_en,
  input wire logic [ADDR_W-1:0] rx_cnt_addr,
  input wire logic rx_stat_en,
  input wire logic [ADDR_W-1:0] rx_stat_addr,
  input wire logic [ADDR_W-1:0] rx_dyn_addr,
  input wire logic [ADDR_W-1:0] rx_data_addr,
  input wire logic rx_ext_id,
  input wire logic [3:0] rx_max_len
);
  localparam int MS_W = $clog2(MS_TICKS + 1);
  localparam logic [3:0] PAYLOAD_MAX = 4'(MAX_PAYLOAD);

  logic [7:0] mem [MEM_DEPTH];
  logic [MS_W-1:0] ms_cnt_reg;
  logic ms_tick;
  logic [ADDR_W-1:0] tx_time_a, tx_len_a, rx_time_a, rx_len_a;
  logic [ADDR_W-1:0] tx_id_a [4];
  logic [ADDR_W-1:0] rx_id_a [4];
  logic [28:0] tx_id_cur, rx_id_cur;
  logic [15:0] tx_int, tx_int_eff, rx_to, rx_to_eff;
  logic [3:0] tx_len_cur, rx_len_cur;
  logic tx_rtr_cur;
  logic [63:0] tx_live, tx_out, freeze_reg, sent_data_reg;
  logic [15:0] cyc_cnt_reg, to_cnt_reg;
  logic [7:0] trig_prev_reg;
  logic shot_done_reg, pend_reg, tx_valid_reg, tx_done;
  logic fire, launch, tx_allowed;
  logic [28:0] tx_id_reg;
  logic tx_ext_reg, tx_rtr_reg;
  logic [3:0] tx_len_reg;
  logic [63:0] tx_data_reg;
  logic rx_match, rx_accept, rx_bad;
  logic [2:0] stat_reg, stat_sent_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  // Clamp a length field to the configured maximum and eight bytes.
  function automatic logic [3:0] cap_len(input logic [3:0] l,
                                         input logic [3:0] m);
    logic [3:0] c;
    c = (l > m) ? m : l;
    return (c > PAYLOAD_MAX) ? PAYLOAD_MAX : c;
  endfunction

  // Free-running millisecond tick; long count is a parameter for sims.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ms_cnt_reg <= '0;
    end else if (ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end
  assign ms_tick = (ms_cnt_reg == MS_W'(MS_TICKS - 1));

  // Decode both parameter blocks straight out of memory every cycle.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      tx_id_a[k] = tx_dyn_addr + ADDR_W'(k);
      rx_id_a[k] = rx_dyn_addr + ADDR_W'(k);
    end
    tx_time_a = tx_dyn_addr + ADDR_W'(tx_ext_id ? ID_BYTES_EXT
                                                : ID_BYTES_STD);
    rx_time_a = rx_dyn_addr + ADDR_W'(rx_ext_id ? ID_BYTES_EXT
                                                : ID_BYTES_STD);
    tx_len_a = tx_time_a + ADDR_W'(OFS_LEN_REL);
    rx_len_a = rx_time_a + ADDR_W'(OFS_LEN_REL);
    tx_id_cur = 29'({mem[tx_id_a[3]], mem[tx_id_a[2]], mem[tx_id_a[1]],
                     mem[tx_id_a[0]]});
    rx_id_cur = 29'({mem[rx_id_a[3]], mem[rx_id_a[2]], mem[rx_id_a[1]],
                     mem[rx_id_a[0]]});
    if (!tx_ext_id) tx_id_cur[28:STD_ID_W] = '0;
    if (!rx_ext_id) rx_id_cur[28:STD_ID_W] = '0;
    tx_int = {mem[tx_time_a + ADDR_W'(OFS_TIME_REL + 1)],
              mem[tx_time_a + ADDR_W'(OFS_TIME_REL)]};
    rx_to = {mem[rx_time_a + ADDR_W'(OFS_TIME_REL + 1)],
             mem[rx_time_a + ADDR_W'(OFS_TIME_REL)]};
    // Illegal small times are lifted to the lowest legal value.
    tx_int_eff = (tx_int != '0 && tx_int < TX_TIME_MIN) ? TX_TIME_MIN
                                                        : tx_int;
    rx_to_eff = (rx_to != '0 && rx_to < RX_TIME_MIN) ? RX_TIME_MIN
                                                     : rx_to;
    tx_len_cur = cap_len(mem[tx_len_a][LEN_W-1:0], tx_max_len);
    rx_len_cur = cap_len(mem[rx_len_a][LEN_W-1:0], rx_max_len);
    tx_rtr_cur = mem[tx_len_a][RTR_BIT];
    for (int i = 0; i < MAX_PAYLOAD; i++) begin
      tx_live[i*8 +: 8] = (4'(i) < tx_len_cur) ?
                          mem[tx_data_addr + ADDR_W'(i)] : 8'h00;
    end
  end

  // Offline data choice for the transmit side.
  assign tx_out = link.fb_online ? tx_live :
                  (tx_offline_mode == TX_OFF_FREEZE) ? freeze_reg
                                                     : '0;
  assign tx_allowed = link.fb_online ||
                      (tx_offline_mode != TX_OFF_STOP);

  // Scheduler event: one source per update mode.
  always_comb begin
    case (tx_update_mode)
      UPD_CYCLIC: fire = ms_tick && tx_int_eff != '0 &&
                         cyc_cnt_reg + 16'h0001 >= tx_int_eff;
      UPD_CHANGE: fire = (tx_out != sent_data_reg) && !pend_reg &&
                         !tx_valid_reg;
      UPD_SINGLE: fire = !shot_done_reg && !pend_reg;
      UPD_TRIGGER: fire = mem[tx_trig_addr] != trig_prev_reg;
      default: fire = 1'b0;
    endcase
  end
  assign launch = pend_reg && !tx_valid_reg && tx_allowed;
  assign tx_done = tx_valid_reg && link.tx_ready;

  // Cyclic interval counter; a zero interval parks it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_cnt_reg <= '0;
    end else if (tx_update_mode != UPD_CYCLIC || tx_int_eff == '0) begin
      cyc_cnt_reg <= '0;
    end else if (ms_tick) begin
      cyc_cnt_reg <= fire ? 16'h0000 : cyc_cnt_reg + 16'h0001;
    end
  end

  // Pending launch; a new event in the launch cycle is kept.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
      shot_done_reg <= 1'b0;
      trig_prev_reg <= 8'h00;
      sent_data_reg <= '0;
      freeze_reg <= '0;
    end else begin
      pend_reg <= (fire && tx_allowed) || (pend_reg && !launch);
      trig_prev_reg <= mem[tx_trig_addr];
      if (launch) shot_done_reg <= 1'b1;
      if (launch) sent_data_reg <= tx_out;
      if (link.fb_online) freeze_reg <= tx_live;
    end
  end

  // Frame register: the block is sampled at launch. One engine only.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_valid_reg <= 1'b0;
      tx_id_reg <= '0;
      tx_ext_reg <= 1'b0;
      tx_rtr_reg <= 1'b0;
      tx_len_reg <= '0;
      tx_data_reg <= '0;
    end else if (launch) begin
      tx_valid_reg <= 1'b1;
      tx_id_reg <= tx_id_cur;
      tx_ext_reg <= tx_ext_id;
      tx_rtr_reg <= tx_rtr_cur;
      tx_len_reg <= tx_len_cur;
      tx_data_reg <= tx_out;
    end else if (tx_done) begin
      tx_valid_reg <= 1'b0;
    end
  end
  assign link.tx_valid = tx_valid_reg;
  assign link.tx_id = tx_id_reg;
  assign link.tx_ext = tx_ext_reg;
  assign link.tx_rtr = tx_rtr_reg;
  assign link.tx_len = tx_len_reg;
  assign link.tx_data = tx_data_reg;

  // Receive match against the live block; one receive engine only.
  assign rx_match = link.rx_valid && link.can_online &&
                    link.rx_ext == rx_ext_id &&
                    link.rx_id == rx_id_cur;
  assign rx_accept = rx_match && link.rx_len >= rx_len_cur;
  assign rx_bad = rx_match && link.rx_len < rx_len_cur;

  // Timeout counter and status bits; reception resets the wait.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      to_cnt_reg <= '0;
      stat_reg <= STAT_RESET;
      stat_sent_reg <= 3'h0;
    end else begin
      stat_sent_reg <= stat_reg;
      if (rx_accept) begin
        to_cnt_reg <= '0;
        stat_reg <= 3'h0;
      end else begin
        if (ms_tick && to_cnt_reg != 16'hFFFF)
          to_cnt_reg <= to_cnt_reg + 16'h0001;
        if (rx_to_eff != '0 && to_cnt_reg >= rx_to_eff)
          stat_reg[STAT_TIMEOUT_BIT] <= 1'b1;
        if (rx_bad) stat_reg[STAT_DERR_BIT] <= 1'b1;
      end
    end
  end

  // Single memory writer; engine writes override a master write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int a = 0; a < MEM_DEPTH; a++) mem[a] <= MEM_RESET;
    end else begin
      if (link.mem_wr) mem[link.mem_addr] <= link.mem_wdata;
      if (!link.can_online && rx_offline_mode == RX_OFF_CLEAR) begin
        for (int i = 0; i < MAX_PAYLOAD; i++)
          if (4'(i) < rx_max_len)
            mem[rx_data_addr + ADDR_W'(i)] <= 8'h00;
      end
      if (rx_accept) begin
        for (int i = 0; i < MAX_PAYLOAD; i++)
          if (4'(i) < rx_len_cur)
            mem[rx_data_addr + ADDR_W'(i)] <= link.rx_data[i*8 +: 8];
      end
      if (rx_accept && rx_cnt_en)
        mem[rx_cnt_addr] <= mem[rx_cnt_addr] + 8'h01;
      if (tx_done && tx_cnt_en)
        mem[tx_cnt_addr] <= mem[tx_cnt_addr] + 8'h01;
      if (rx_stat_en && stat_reg != stat_sent_reg)
        mem[rx_stat_addr] <= {5'h00, stat_reg};
    end
  end

  // Master read port answers one cycle after the request.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= link.mem_rd;
      if (link.mem_rd) rdata_reg <= mem[link.mem_addr];
    end
  end
  assign link.mem_rdata = rdata_reg;
  assign link.mem_rvalid = rvalid_reg;
endmodule

// ### can_dyn_peer.sv
// Peer end: fieldbus master block writer plus a CAN node front.
module can_dyn_peer
  import can_dyn_pkg::*;
#(
  parameter int ADDR_W = DEF_ADDR_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Link to the gateway.
  can_dyn_if.peer link,
  // Raw byte access to process memory.
  input wire logic usr_wr,
  input wire logic usr_rd,
  input wire logic [ADDR_W-1:0] usr_addr,
  input wire logic [7:0] usr_wdata,
  output logic [7:0] usr_rdata,
  output logic usr_rvalid,
  // Whole parameter block write.
  input wire logic blk_go,
  input wire logic blk_is_tx,
  input wire logic blk_ext,
  input wire logic [ADDR_W-1:0] blk_base,
  input wire logic [28:0] blk_id,
  input wire logic [15:0] blk_time,
  input wire logic [3:0] blk_len,
  input wire logic blk_rtr,
  output logic blk_busy,
  // Network states.
  input wire logic fb_online_in,
  input wire logic can_online_in,
  // CAN node: frames out of the gateway.
  input wire logic node_tx_ready,
  output logic node_tx_seen,
  output logic [28:0] node_tx_id,
  output logic node_tx_ext,
  output logic node_tx_rtr,
  output logic [3:0] node_tx_len,
  output logic [63:0] node_tx_data,
  // CAN node: frames into the gateway.
  input wire logic node_rx_valid,
  input wire logic [28:0] node_rx_id,
  input wire logic node_rx_ext,
  input wire logic [3:0] node_rx_len,
  input wire logic [63:0] node_rx_data
);
  seq_state_t state_reg;
  logic [7:0] buf_reg [7];
  logic [2:0] idx_reg, last_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [15:0] time_c, tmin;
  logic [3:0] len_c;
  logic [7:0] len_byte;
  logic [31:0] id_c;
  logic [28:0] rx_id_reg, tx_id_reg;
  logic rx_valid_reg, rx_ext_reg, tx_seen_reg, tx_ext_reg, tx_rtr_reg;
  logic [3:0] rx_len_reg, tx_len_reg;
  logic [63:0] rx_data_reg, tx_data_reg;
  logic fb_reg, can_reg;

  // Legalise the block fields before they reach memory.
  always_comb begin
    tmin = blk_is_tx ? TX_TIME_MIN : RX_TIME_MIN;
    time_c = (blk_time != '0 && blk_time < tmin) ? tmin
                                                 : blk_time;
    len_c = (blk_len > 4'(MAX_PAYLOAD)) ? 4'(MAX_PAYLOAD) : blk_len;
    len_byte = {3'h0, blk_is_tx & blk_rtr, len_c};
    id_c = {3'h0, blk_ext ? blk_id : {18'h00000, blk_id[10:0]}};
  end

  // Byte sequencer writes the block low byte first.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SEQ_IDLE;
      idx_reg <= '0;
      last_reg <= '0;
      base_reg <= '0;
      for (int i = 0; i < 7; i++) buf_reg[i] <= 8'h00;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          if (blk_go) begin
            state_reg <= SEQ_WRITE;
            idx_reg <= '0;
            base_reg <= blk_base;
            last_reg <= blk_ext ? 3'(ID_BYTES_EXT + BLK_TAIL_BYTES - 1)
                                : 3'(ID_BYTES_STD + BLK_TAIL_BYTES - 1);
            if (blk_ext) begin
              {buf_reg[3], buf_reg[2], buf_reg[1], buf_reg[0]} <= id_c;
              {buf_reg[5], buf_reg[4]} <= time_c;
              buf_reg[6] <= len_byte;
            end else begin
              {buf_reg[1], buf_reg[0]} <= id_c[15:0];
              {buf_reg[3], buf_reg[2]} <= time_c;
              buf_reg[4] <= len_byte;
            end
          end
        end
        SEQ_WRITE: begin
          if (idx_reg == last_reg) state_reg <= SEQ_IDLE;
          idx_reg <= idx_reg + 3'h1;
        end
        default: state_reg <= SEQ_IDLE;
      endcase
    end
  end
  assign blk_busy = (state_reg == SEQ_WRITE);

  // Memory port: block writes lock out raw access while busy.
  always_comb begin
    link.mem_wr = blk_busy || usr_wr;
    link.mem_rd = !blk_busy && usr_rd;
    link.mem_addr = blk_busy ? base_reg + ADDR_W'(idx_reg) : usr_addr;
    link.mem_wdata = blk_busy ? buf_reg[idx_reg] : usr_wdata;
  end
  assign usr_rdata = link.mem_rdata;
  assign usr_rvalid = link.mem_rvalid;

  // Registered received frames and network state towards the gateway; the node's tx_ready passes straight through.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_valid_reg <= 1'b0;
      rx_id_reg <= '0;
      rx_ext_reg <= 1'b0;
      rx_len_reg <= '0;
      rx_data_reg <= '0;
      fb_reg <= 1'b0;
      can_reg <= 1'b0;
    end else begin
      rx_valid_reg <= node_rx_valid;
      fb_reg <= fb_online_in;
      can_reg <= can_online_in;
      if (node_rx_valid) begin
        rx_id_reg <= node_rx_id;
        rx_ext_reg <= node_rx_ext;
        rx_len_reg <= (node_rx_len > 4'(MAX_PAYLOAD)) ? 4'(MAX_PAYLOAD)
                                                     : node_rx_len;
        rx_data_reg <= node_rx_data;
      end
    end
  end
  assign link.rx_valid = rx_valid_reg;
  assign link.rx_id = rx_id_reg;
  assign link.rx_ext = rx_ext_reg;
  assign link.rx_len = rx_len_reg;
  assign link.rx_data = rx_data_reg;
  assign link.fb_online = fb_reg;
  assign link.can_online = can_reg;
  assign link.tx_ready = node_tx_ready;

  // Capture each frame the gateway hands over.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_seen_reg <= 1'b0;
      tx_id_reg <= '0;
      tx_ext_reg <= 1'b0;
      tx_rtr_reg <= 1'b0;
      tx_len_reg <= '0;
      tx_data_reg <= '0;
    end else begin
      tx_seen_reg <= link.tx_valid && node_tx_ready;
      if (link.tx_valid && node_tx_ready) begin
        tx_id_reg <= link.tx_id;
        tx_ext_reg <= link.tx_ext;
        tx_rtr_reg <= link.tx_rtr;
        tx_len_reg <= link.tx_len;
        tx_data_reg <= link.tx_data;
      end
    end
  end
  assign node_tx_seen = tx_seen_reg;
  assign node_tx_id = tx_id_reg;
  assign node_tx_ext = tx_ext_reg;
  assign node_tx_rtr = tx_rtr_reg;
  assign node_tx_len = tx_len_reg;
  assign node_tx_data = tx_data_reg;
endmodule

// ### can_dyn_chk.sv
// Checker of the link between gateway and peer.
module can_dyn_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Memory port.
  input wire logic mem_rd,
  input wire logic mem_rvalid,
  // Frames on the link.
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic tx_ext,
  input wire logic tx_rtr,
  input wire logic [3:0] tx_len,
  input wire logic [63:0] tx_data,
  input wire logic rx_valid,
  input wire logic [3:0] rx_len
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so the reset is given once for every check.
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_answered: assert property (mem_rd |=> mem_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (mem_rvalid |-> $past(mem_rd))
    else $error("read answer without request");
  a_tx_frame_held: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable({tx_id, tx_ext, tx_rtr, tx_len, tx_data}))
    else $error("frame changed before handshake");
  a_tx_released: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("frame still offered after handshake");
  a_tx_len_cap: assert property (tx_valid |-> tx_len <= 4'h8)
    else $error("transmit length above eight");
  a_tx_tail_zero: assert property (tx_valid && tx_len < 4'h8 |->
    (tx_data >> {tx_len, 3'h0}) == 64'h0)
    else $error("bytes beyond length not zero");
  a_std_id_width: assert property (tx_valid && !tx_ext |->
    tx_id[28:11] == 18'h0)
    else $error("standard identifier wider than 11 bits");
  a_rx_len_cap: assert property (rx_valid |-> rx_len <= 4'h8)
    else $error("receive length above eight");
endmodule

// ### tb_top.sv
// Testbench joining gateway and peer through the link interface.
module tb_top
  import can_dyn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic resetn = 0;
  int errors = 0;
  int checks = 0;
  // Static configuration of both transactions.
  tx_offline_t tx_offline_mode = TX_OFF_STOP;
  update_mode_t tx_update_mode = UPD_TRIGGER;
  rx_offline_t rx_offline_mode = RX_OFF_CLEAR;
  logic tx_cnt_en = 1, rx_cnt_en = 1, rx_stat_en = 1, tx_ext_id = 0;
  logic rx_ext_id = 1;
  logic [8:0] tx_dyn_addr = 9'h100, tx_data_addr = 9'h110;
  logic [8:0] tx_trig_addr = 9'h120, tx_cnt_addr = 9'h121;
  logic [8:0] rx_dyn_addr = 9'h130, rx_data_addr = 9'h140;
  logic [8:0] rx_cnt_addr = 9'h150, rx_stat_addr = 9'h151;
  logic [3:0] tx_max_len = 4'h4, rx_max_len = 4'h8;
  // Peer user side.
  logic usr_wr = 0, usr_rd = 0, usr_rvalid, blk_busy, node_tx_seen;
  logic [8:0] usr_addr = 0, blk_base = 0;
  logic [7:0] usr_wdata = 0, usr_rdata;
  logic blk_go = 0, blk_is_tx = 0, blk_ext = 0, blk_rtr = 0;
  logic [28:0] blk_id = 0, node_tx_id, node_rx_id = 0;
  logic [15:0] blk_time = 0;
  logic [3:0] blk_len = 0, node_tx_len, node_rx_len = 0;
  logic fb_online_in = 1, can_online_in = 1, node_tx_ready = 1;
  logic node_tx_ext, node_tx_rtr, node_rx_valid = 0, node_rx_ext = 1;
  logic [63:0] node_tx_data, node_rx_data = 0;
  bit s;

  can_dyn_if link ();
  can_dyn_gateway #(.MS_TICKS(10)) can_dyn_gateway_i (.clk, .resetn,
    .link(link.gateway), .tx_offline_mode, .tx_update_mode, .tx_cnt_en,
    .tx_cnt_addr, .tx_trig_addr, .tx_dyn_addr, .tx_data_addr, .tx_ext_id,
    .tx_max_len, .rx_offline_mode, .rx_cnt_en, .rx_cnt_addr, .rx_stat_en,
    .rx_stat_addr, .rx_dyn_addr, .rx_data_addr, .rx_ext_id, .rx_max_len);
  can_dyn_peer can_dyn_peer_i (.clk, .resetn, .link(link.peer), .usr_wr,
    .usr_rd, .usr_addr, .usr_wdata, .usr_rdata, .usr_rvalid, .blk_go,
    .blk_is_tx, .blk_ext, .blk_base, .blk_id, .blk_time, .blk_len,
    .blk_rtr, .blk_busy, .fb_online_in, .can_online_in, .node_tx_ready,
    .node_tx_seen, .node_tx_id, .node_tx_ext, .node_tx_rtr, .node_tx_len,
    .node_tx_data, .node_rx_valid, .node_rx_id, .node_rx_ext,
    .node_rx_len, .node_rx_data);
  can_dyn_chk can_dyn_chk_i (.clk, .resetn, .mem_rd(link.mem_rd),
    .mem_rvalid(link.mem_rvalid), .tx_valid(link.tx_valid),
    .tx_ready(link.tx_ready), .tx_id(link.tx_id), .tx_ext(link.tx_ext),
    .tx_rtr(link.tx_rtr), .tx_len(link.tx_len), .tx_data(link.tx_data),
    .rx_valid(link.rx_valid), .rx_len(link.rx_len));

  // A 50 ns clock.
  always #25 clk = ~clk;

  // Counts the comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [63:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Inputs always move 5 ns after the edge, clear of sampling.
  task automatic step();
    @(posedge clk);
    #5;
  endtask
  task automatic tmo();
    errors++;
    $display("Error wait expected handshake seen none");
    final_report();
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    step();
    usr_wr = 1;
    usr_addr = a;
    usr_wdata = d;
    step();
    usr_wr = 0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    int n;
    step();
    usr_rd = 1;
    usr_addr = a;
    step();
    usr_rd = 0;
    for (n = 0; n < 4 && usr_rvalid !== 1'b1; n++) step();
    if (n == 4) tmo();
    chk($sformatf("mem_%0h", a), e, usr_rdata);
  endtask
  task automatic blk(input logic t, x, input logic [8:0] b,
      input logic [28:0] id, input logic [3:0] ln, input logic r);
    int n;
    step();
    blk_go = 1;
    blk_is_tx = t;
    blk_ext = x;
    blk_base = b;
    blk_id = id;
    blk_len = ln;
    blk_rtr = r;
    step();
    blk_go = 0;
    for (n = 0; n < 12 && blk_busy !== 1'b0; n++) step();
    if (n == 12) tmo();
  endtask
  // A frame is only seen as a one-cycle pulse, so it is polled each cycle.
  task automatic wait_tx(output bit seen);
    seen = 0;
    for (int n = 0; n < 60 && !seen; n++) begin
      step();
      seen = (node_tx_seen === 1'b1);
    end
  endtask
  task automatic rxf(input logic [28:0] id, input logic [3:0] ln,
      input logic [63:0] d);
    step();
    node_rx_valid = 1;
    node_rx_id = id;
    node_rx_len = ln;
    node_rx_data = d;
    step();
    node_rx_valid = 0;
    repeat (4) step();
  endtask
  task automatic tx_case(input logic [7:0] k, input logic [3:0] ln,
      input logic r, input logic [63:0] d);
    wr(tx_trig_addr, k);
    wait_tx(s);
    chk("tx_seen", 1, s);
    chk("tx_id", 29'h123, node_tx_id);
    chk("tx_ext", 0, node_tx_ext);
    chk("tx_rtr", r, node_tx_rtr);
    chk("tx_len", ln, node_tx_len);
    chk("tx_data", d, node_tx_data);
    rd(tx_cnt_addr, k);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    repeat (4) @(posedge clk);
    #5 resetn = 1;
    for (int i = 0; i < 5; i++) rd(tx_dyn_addr + 9'(i), 8'h00);
    rd(rx_stat_addr, 8'h04);
    $display("test reset done");
    for (int i = 0; i < 8; i++) wr(tx_data_addr + 9'(i), 8'(17 * (i + 1)));
    blk(1, 0, tx_dyn_addr, 29'h123, 4'h3, 1);
    rd(tx_dyn_addr, 8'h23);
    rd(tx_dyn_addr + 9'h1, 8'h01);
    tx_case(8'h01, 4'h3, 1, 64'h332211);
    // Length above the maximum is cut back to four bytes.
    blk(1, 0, tx_dyn_addr, 29'h123, 4'hF, 0);
    tx_case(8'h02, 4'h4, 0, 64'h44332211);
    fb_online_in = 0;
    wr(tx_trig_addr, 8'h03);
    wait_tx(s);
    chk("tx_stopped", 0, s);
    fb_online_in = 1;
    // A stalled node must see the frame held, then take it once.
    node_tx_ready = 0;
    wr(tx_trig_addr, 8'h04);
    repeat (4) step();
    chk("tx_held", 1, link.tx_valid);
    node_tx_ready = 1;
    wait_tx(s);
    chk("tx_late", 1, s);
    rd(tx_cnt_addr, 8'h03);
    // Five ms interval, then a zero interval parks the schedule.
    wr(tx_dyn_addr + 9'h2, 8'h05);
    tx_update_mode = UPD_CYCLIC;
    wait_tx(s);
    chk("tx_cyclic", 1, s);
    wr(tx_dyn_addr + 9'h2, 8'h00);
    wait_tx(s);
    chk("tx_halted", 0, s);
    // A data change sends; going offline sends cleared data.
    tx_offline_mode = TX_OFF_CLEAR;
    tx_update_mode = UPD_CHANGE;
    wr(tx_data_addr, 8'h99);
    wait_tx(s);
    chk("tx_change", 64'h44332299, node_tx_data);
    fb_online_in = 0;
    wait_tx(s);
    chk("tx_cleared", 0, node_tx_data);
    fb_online_in = 1;
    wait_tx(s);
    chk("tx_resend", 1, s);
    $display("test transmit done");
    blk(0, 1, rx_dyn_addr, 29'h1ABCDE12, 4'h2, 0);
    rxf(29'h1ABCDE12, 4'h2, 64'hBEEF);
    rd(rx_data_addr, 8'hEF);
    rd(rx_data_addr + 9'h1, 8'hBE);
    rd(rx_cnt_addr, 8'h01);
    rd(rx_stat_addr, 8'h00);
    rxf(29'h1ABCDE13, 4'h2, 64'h1234);
    rd(rx_cnt_addr, 8'h01);
    rxf(29'h1ABCDE12, 4'h1, 64'h55);
    rd(rx_stat_addr, 8'h02);
    rd(rx_data_addr, 8'hEF);
    can_online_in = 0;
    repeat (3) step();
    rd(rx_data_addr, 8'h00);
    // Held data stays while offline; a silent node then times out.
    rx_offline_mode = RX_OFF_FREEZE;
    wr(rx_data_addr, 8'h5A);
    rd(rx_data_addr, 8'h5A);
    wr(rx_dyn_addr + 9'h4, 8'h0A);
    repeat (120) step();
    rd(rx_stat_addr, 8'h03);
    $display("test receive done");
    // A second reset in mid-run: one single-shot frame, then silence.
    tx_update_mode = UPD_SINGLE;
    resetn = 0;
    repeat (2) step();
    resetn = 1;
    wait_tx(s);
    chk("tx_single", 1, s);
    wait_tx(s);
    chk("tx_once", 0, s);
    rd(rx_stat_addr, 8'h04);
    $display("test second reset done");
    final_report();
  end
endmodule
